/* File: design/frw_pkg.sv */
// Purpose: Shared constants, types and decoders for the fault retry and warning supervisor.
// Assumes: One 25 MHz system clock and a synchronous active-high reset.
// Notes: Lookup tables for the 3-bit fields are parameters of the top module.
package frw_pkg;

  localparam int CLK_PERIOD_NS = 40;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int FAST_ON_US = 100;
  localparam int FAST_ON_CYCLES = (FAST_ON_US * 1000) / CLK_PERIOD_NS;
  localparam int MS_W = 17;
  localparam int CNT_W = 6;
  localparam int FAST_W = 12;
  localparam int NUM_WARN = 13;

  localparam int WI_GATE_LOW = 0;
  localparam int WI_EXT_OVERTEMP = 1;
  localparam int WI_DIE_OVERTEMP = 2;
  localparam int WI_IN_UNDERVOLT = 3;
  localparam int WI_IN_OVERVOLT = 4;
  localparam int WI_OUT_OVERVOLT = 5;
  localparam int WI_OUT_UNDERVOLT = 6;
  localparam int WI_SAFE_AREA = 7;
  localparam int WI_OUT_UNDERCURRENT = 8;
  localparam int WI_OUT_OVERCURRENT = 9;
  localparam int WI_NEG_CURRENT = 10;
  localparam int WI_IN_OVERPOWER = 11;
  localparam int WI_BUS_ERROR = 12;

  localparam logic [CNT_W-1:0] USED_RESET = 6'h00;
  localparam logic [FAST_W-1:0] FAST_RESET = 12'h000;

  typedef enum logic [3:0] {
    CS_POR_INIT, CS_READ_CFG, CS_SWITCH_CHECK, CS_STANDBY, CS_SOFTSTART,
    CS_ON, CS_CURRENT_REG, CS_FAULT, CS_LATCHED
  } frw_ctrl_e;

  typedef enum logic [1:0] {SV_RUN, SV_COOLDOWN, SV_LATCH, SV_MEM_LATCH} frw_sv_e;

  typedef struct packed {
    logic output_undervoltage;
    logic powerup_watchdog;
    logic overcurrent;
    logic safe_area_regulation;
    logic severe_overcurrent;
  } frw_retry_fault_s;

  typedef struct packed {
    logic memory;
    logic drain_source_short;
    logic gate_drain_short;
    logic gate_source_short;
  } frw_latch_fault_s;

  typedef struct packed {
    logic unsuccessful_retry;
    frw_latch_fault_s latch;
    frw_retry_fault_s retry;
  } frw_fault_status_s;

  typedef logic [NUM_WARN-1:0] frw_warn_t;
  typedef logic [7:0][CNT_W-1:0] frw_count_lut_t;
  typedef logic [7:0][MS_W-1:0] frw_ms_lut_t;

  localparam frw_fault_status_s FAULT_STATUS_RESET = '0;
  localparam frw_warn_t WARN_RESET = 13'h0000;

  // Tells whether a warning is processed in the given controller state.
  function automatic logic frw_warn_active(input int unsigned idx, input frw_ctrl_e st);
    logic on_states;
    logic wide_states;
    logic active;
    on_states = (st == CS_ON) || (st == CS_CURRENT_REG);
    wide_states = (st == CS_STANDBY) || (st == CS_SOFTSTART) || on_states || (st == CS_FAULT);
    if (idx == WI_GATE_LOW)
      active = (st == CS_ON);
    else if (idx == WI_IN_OVERPOWER)
      active = (st == CS_SOFTSTART) || on_states;
    else if (idx == WI_BUS_ERROR)
      active = wide_states || (st == CS_LATCHED);
    else if (idx <= WI_OUT_OVERVOLT)
      active = wide_states;
    else
      active = on_states;
    return active;
  endfunction

endpackage

/* File: design/frw_ms_timer.sv */
// Purpose: Millisecond down-counter used for cool-down and retry-success deglitch.
// Assumes: tick is a one-cycle pulse once per millisecond.
// Notes: A load of zero finishes on the next clock without waiting for a tick.
`timescale 1ns/1ps
`default_nettype none
module frw_ms_timer
  import frw_pkg::*;
(
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic abort,
  input wire logic tick,
  input wire logic [MS_W-1:0] load_ms,
  output logic busy,
  output logic done
);

  logic [MS_W-1:0] count_reg;
  logic [MS_W-1:0] count_next;
  logic busy_reg;
  logic busy_next;
  logic done_reg;
  logic done_next;

  always_comb
  begin
    count_next = count_reg;
    busy_next = busy_reg;
    done_next = 1'b0;
    if (abort)
      busy_next = 1'b0;
    else if (start)
    begin
      count_next = load_ms;
      busy_next = 1'b1;
    end
    else if (busy_reg && (count_reg == '0))
    begin
      busy_next = 1'b0;
      done_next = 1'b1;
    end
    else if (busy_reg && tick)
      count_next = count_reg - 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      count_reg <= '0;
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      count_reg <= count_next;
      busy_reg <= busy_next;
      done_reg <= done_next;
    end
  end

  assign busy = busy_reg;
  assign done = done_reg;

endmodule // frw_ms_timer
`default_nettype wire

/* File: design/frw_supervisor.sv */
// Purpose: Retry pacing, latch-off handling and warning gating for a hot-swap controller.
// Assumes: Fault inputs are one-cycle event pulses; warning inputs are condition levels.
// Notes: Field decoding tables are parameters until their final values are settled.
//
// Summary of operation
// - Only the five retryable faults may retry, each gated by its own retry mask bit.
// - A 3-bit retry count field selects zero to 32 allowed retries.
// - With the counter disabled, retries go on forever and never raise unsuccessful retry.
// - Each retry except a fast-recovery one waits a cool-down set by a 3-bit field while staying in fault.
// - Clear-faults and enable toggling are ignored during cool-down.
// - After a retry reaches on, a deglitch timer reloads the retry counter if fault-free.
// - Exhausted retries raise unsuccessful retry and move to latch-off.
// - Fast recovery skips the cool-down after a severe overcurrent fault.
// - Fast recovery turns the strong gate pull-up on in soft-start without regulation.
// - Fast-recovery retries use the same counter and latch off when it expires.
// - Latch-off keeps the switch off and freezes status pins and all status bits except the bus-error warning.
// - Outside cool-down, memory and switch short faults latch off at once without retry.
// - With the counter enabled, a retry count of zero latches off on the first retryable fault.
// - Only reset leaves memory latch-off; clear-faults and the enable edge do not.
// - Clear-faults or enable falling edge leaves latch-off, clears status, restarts at switch check.
// - Warnings never turn the switch off; each sets its own status bit.
// - A mask picks warnings for the pin, which drops when conditions clear, except bus error, which holds it until its status clears.
// - A warning whose enable bit is clear is neither detected nor reported.
// - Warning status stays set until clear-faults, restart or power cycle.
// - Each warning is processed only in its own set of controller states.
// - Gate-low warning follows the gate comparator level in the on state.
// - Every retry with the counter enabled consumes one count; none left raises unsuccessful retry.
`timescale 1ns/1ps
`default_nettype none
module frw_supervisor
  import frw_pkg::*;
#(
  parameter int unsigned MS_CYCLES_P = MS_CYCLES,
  parameter frw_count_lut_t COUNT_LUT = {6'd32, 6'd16, 6'd8, 6'd4, 6'd3, 6'd2, 6'd1, 6'd0},
  parameter frw_ms_lut_t COOLDOWN_LUT = {17'd64000, 17'd32000, 17'd16000, 17'd8000,
                                         17'd4000, 17'd1000, 17'd100, 17'd0},
  parameter frw_ms_lut_t DEGLITCH_LUT = {17'd10000, 17'd5000, 17'd2000, 17'd1000,
                                         17'd500, 17'd100, 17'd10, 17'd1}
)
(
  input wire logic mclk,
  input wire logic reset,
  input wire frw_ctrl_e ctrl_state,
  input wire frw_retry_fault_s retry_fault,
  input wire frw_latch_fault_s latch_fault,
  input wire frw_retry_fault_s retry_mask,
  input wire logic [2:0] retry_count_field,
  input wire logic retry_counter_disable,
  input wire logic [2:0] cooldown_time_field,
  input wire logic [2:0] retry_ok_deglitch_field,
  input wire logic gate_fast_recovery_enable,
  input wire logic no_regulation_needed,
  input wire logic clear_faults,
  input wire logic enable_pin,
  input wire logic enable_pin_is_enable,
  input wire logic power_good_cond,
  input wire frw_warn_t warn_cond,
  input wire frw_warn_t warn_enable,
  input wire frw_warn_t warn_mask,
  output logic switch_off,
  output logic retry_start,
  output logic switch_check_start,
  output logic strong_pullup,
  output logic latch_off,
  output logic mem_latch_off,
  output logic [CNT_W-1:0] retries_used,
  output frw_fault_status_s fault_status,
  output frw_warn_t warning_status,
  output logic warning_pin,
  output logic fault_pin,
  output logic power_good_pin
);

  frw_sv_e sv_reg, sv_next;
  logic [CNT_W-1:0] used_reg, used_next;
  logic retried_reg, retried_next;
  logic retry_start_reg, retry_start_next;
  logic check_reg, check_next;
  logic en_prev_reg;
  frw_ctrl_e ctrl_prev_reg;
  logic [31:0] presc_reg, presc_next;
  logic tick_reg, tick_next;
  logic [FAST_W-1:0] fast_reg, fast_next;
  logic pullup_reg, pullup_next;
  frw_fault_status_s fstat_reg, fstat_next;
  frw_warn_t wstat_reg, wstat_next;
  logic wpin_reg, wpin_next;
  logic fpin_reg, fpin_next;
  logic pg_reg, pg_next;
  logic off_reg, off_next;
  frw_warn_t qual;
  frw_warn_t pin_level;
  logic any_retry, retry_allowed, latch_hit, en_fall, frozen, clear_ok, fast_skip;
  logic ur_set, release_go, cool_start, cool_done, dg_start, dg_abort, dg_done;
  logic [MS_W-1:0] cool_load;

  assign any_retry = |retry_fault;
  assign retry_allowed = |(retry_fault & retry_mask);
  assign latch_hit = |latch_fault;
  assign en_fall = enable_pin_is_enable && en_prev_reg && !enable_pin;
  assign frozen = (sv_reg == SV_LATCH) || (sv_reg == SV_MEM_LATCH);
  assign clear_ok = clear_faults && (sv_reg == SV_RUN);
  assign fast_skip = gate_fast_recovery_enable && retry_fault.severe_overcurrent;
  assign cool_load = fast_skip ? '0 : COOLDOWN_LUT[cooldown_time_field];
  assign dg_start = (sv_reg == SV_RUN) && retried_reg && (ctrl_state == CS_ON) && (ctrl_prev_reg != CS_ON);
  assign dg_abort = any_retry || latch_hit || (sv_reg != SV_RUN);

  frw_ms_timer u_cooldown (
    .mclk(mclk),
    .reset(reset),
    .start(cool_start),
    .abort(1'b0),
    .tick(tick_reg),
    .load_ms(cool_load),
    .busy(),
    .done(cool_done)
  );

  frw_ms_timer u_deglitch (
    .mclk(mclk),
    .reset(reset),
    .start(dg_start),
    .abort(dg_abort),
    .tick(tick_reg),
    .load_ms(DEGLITCH_LUT[retry_ok_deglitch_field]),
    .busy(),
    .done(dg_done)
  );

  // Retry sequencing; counting used retries lets reset clear to a constant.
  always_comb
  begin
    sv_next = sv_reg;
    used_next = used_reg;
    retried_next = retried_reg;
    retry_start_next = 1'b0;
    check_next = 1'b0;
    cool_start = 1'b0;
    ur_set = 1'b0;
    release_go = 1'b0;
    unique case (sv_reg)
      SV_RUN:
      begin
        if (latch_fault.memory)
          sv_next = SV_MEM_LATCH;
        else if (latch_hit)
          sv_next = SV_LATCH;
        else if (any_retry && !retry_allowed)
          sv_next = SV_LATCH;
        else if (any_retry && retry_counter_disable)
        begin
          sv_next = SV_COOLDOWN;
          cool_start = 1'b1;
        end
        else if (any_retry && (used_reg >= COUNT_LUT[retry_count_field]))
        begin
          ur_set = 1'b1;
          sv_next = SV_LATCH;
        end
        else if (any_retry)
        begin
          used_next = used_reg + 1'b1;
          sv_next = SV_COOLDOWN;
          cool_start = 1'b1;
        end
        else if (dg_done)
        begin
          used_next = USED_RESET;
          retried_next = 1'b0;
        end
      end
      SV_COOLDOWN:
      begin
        if (cool_done)
        begin
          sv_next = SV_RUN;
          retry_start_next = 1'b1;
          retried_next = 1'b1;
        end
      end
      SV_LATCH:
      begin
        if (clear_faults || en_fall)
        begin
          release_go = 1'b1;
          sv_next = SV_RUN;
          check_next = 1'b1;
          used_next = USED_RESET;
          retried_next = 1'b0;
        end
      end
      SV_MEM_LATCH:
        sv_next = SV_MEM_LATCH;
    endcase
  end

  // Warnings are qualified by enable and controller state only; they never feed the switch.
  generate
    for (genvar i = 0; i < NUM_WARN; i++)
    begin : g_warn
      assign qual[i] = warn_cond[i] && warn_enable[i] && frw_warn_active(i, ctrl_state);
      if (i == WI_BUS_ERROR)
      begin : g_sticky
        assign pin_level[i] = wstat_reg[i];
      end
      else
      begin : g_auto
        assign pin_level[i] = qual[i];
      end
    end
  endgenerate

  // Status, pins and the one-millisecond prescaler.
  always_comb
  begin
    presc_next = presc_reg + 32'h0000_0001;
    tick_next = 1'b0;
    if (presc_reg >= MS_CYCLES_P - 1)
    begin
      presc_next = 32'h0000_0000;
      tick_next = 1'b1;
    end
    fstat_next = fstat_reg;
    wstat_next = wstat_reg;
    if (release_go)
    begin
      fstat_next = FAULT_STATUS_RESET;
      wstat_next = WARN_RESET;
    end
    else if (frozen)
      wstat_next[WI_BUS_ERROR] = wstat_reg[WI_BUS_ERROR] | qual[WI_BUS_ERROR];
    else
    begin
      if (clear_ok)
      begin
        fstat_next = FAULT_STATUS_RESET;
        wstat_next = WARN_RESET;
      end
      fstat_next.retry = fstat_next.retry | retry_fault;
      fstat_next.latch = fstat_next.latch | latch_fault;
      fstat_next.unsuccessful_retry = fstat_next.unsuccessful_retry | ur_set;
      wstat_next = wstat_next | qual;
    end
    if (frozen)
    begin
      wpin_next = release_go ? 1'b0 : wpin_reg;
      fpin_next = release_go ? 1'b0 : fpin_reg;
      pg_next = release_go ? 1'b0 : pg_reg;
    end
    else
    begin
      wpin_next = |(pin_level & warn_mask & ~(clear_ok ? 13'h1000 : 13'h0000));
      fpin_next = (sv_next != SV_RUN);
      pg_next = power_good_cond && (sv_next == SV_RUN);
    end
    off_next = (sv_next != SV_RUN);
    fast_next = FAST_RESET;
    pullup_next = 1'b0;
    if (gate_fast_recovery_enable && no_regulation_needed && (sv_reg == SV_RUN) &&
        (ctrl_state == CS_SOFTSTART) && (ctrl_prev_reg != CS_SOFTSTART))
    begin
      fast_next = FAST_W'(FAST_ON_CYCLES);
      pullup_next = 1'b1;
    end
    else if (pullup_reg && (ctrl_state == CS_SOFTSTART) && (fast_reg != FAST_RESET))
    begin
      fast_next = fast_reg - 1'b1;
      pullup_next = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      sv_reg <= SV_RUN;
      used_reg <= USED_RESET;
      retried_reg <= 1'b0;
      retry_start_reg <= 1'b0;
      check_reg <= 1'b0;
      en_prev_reg <= 1'b0;
      ctrl_prev_reg <= CS_POR_INIT;
      presc_reg <= 32'h0000_0000;
      tick_reg <= 1'b0;
      fast_reg <= FAST_RESET;
      pullup_reg <= 1'b0;
      fstat_reg <= FAULT_STATUS_RESET;
      wstat_reg <= WARN_RESET;
      wpin_reg <= 1'b0;
      fpin_reg <= 1'b0;
      pg_reg <= 1'b0;
      off_reg <= 1'b0;
    end
    else
    begin
      sv_reg <= sv_next;
      used_reg <= used_next;
      retried_reg <= retried_next;
      retry_start_reg <= retry_start_next;
      check_reg <= check_next;
      en_prev_reg <= enable_pin;
      ctrl_prev_reg <= ctrl_state;
      presc_reg <= presc_next;
      tick_reg <= tick_next;
      fast_reg <= fast_next;
      pullup_reg <= pullup_next;
      fstat_reg <= fstat_next;
      wstat_reg <= wstat_next;
      wpin_reg <= wpin_next;
      fpin_reg <= fpin_next;
      pg_reg <= pg_next;
      off_reg <= off_next;
    end
  end

  assign switch_off = off_reg;
  assign retry_start = retry_start_reg;
  assign switch_check_start = check_reg;
  assign strong_pullup = pullup_reg;
  assign latch_off = (sv_reg == SV_LATCH);
  assign mem_latch_off = (sv_reg == SV_MEM_LATCH);
  assign retries_used = used_reg;
  assign fault_status = fstat_reg;
  assign warning_status = wstat_reg;
  assign warning_pin = wpin_reg;
  assign fault_pin = fpin_reg;
  assign power_good_pin = pg_reg;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  mem_latch_stays_a: assert property (mem_latch_off |=> mem_latch_off)
    else $error("Memory latch-off was left without reset.");
  latch_switch_off_a: assert property ((latch_off || mem_latch_off) |-> switch_off)
    else $error("Switch not held off in latch-off.");
  status_frozen_a: assert property (latch_off && $past(latch_off) && !$past(release_go) |-> $stable(fault_status))
    else $error("Fault status changed during latch-off.");
  short_latch_a: assert property ((sv_reg == SV_RUN) && latch_fault.gate_source_short |=> latch_off || mem_latch_off)
    else $error("Switch short fault did not latch off at once.");
  zero_count_a: assert property ((sv_reg == SV_RUN) && !latch_hit && retry_allowed && !retry_counter_disable &&
                                 (COUNT_LUT[retry_count_field] == '0) |=> latch_off && fault_status.unsuccessful_retry)
    else $error("Zero retry count did not latch off.");
  no_ur_forever_a: assert property ((sv_reg == SV_RUN) && retry_counter_disable && !fstat_reg.unsuccessful_retry
                                    |=> !fault_status.unsuccessful_retry)
    else $error("Unsuccessful retry raised with the counter disabled.");
  cooldown_ignore_a: assert property ((sv_reg == SV_COOLDOWN) && !cool_done |=> (sv_reg == SV_COOLDOWN) && !switch_check_start)
    else $error("Cool-down was cut short.");
  fast_skip_a: assert property ((sv_reg == SV_RUN) && !latch_hit && retry_allowed && fast_skip &&
                                (retry_counter_disable || (used_reg < COUNT_LUT[retry_count_field]))
                                |-> ##[3:4] retry_start)
    else $error("Fast recovery did not skip the cool-down.");
  release_clear_a: assert property (latch_off && clear_faults |=> switch_check_start && (warning_status == '0) && !fault_pin)
    else $error("Latch-off release did not clear status.");
  pullup_bound_a: assert property (strong_pullup |-> (ctrl_prev_reg == CS_SOFTSTART) && gate_fast_recovery_enable)
    else $error("Strong pull-up outside fast soft-start.");

  cover_retry_c: cover property (retry_start ##[1:1000] dg_done);
  cover_ur_c: cover property ($rose(fault_status.unsuccessful_retry));
  cover_release_c: cover property (latch_off ##1 switch_check_start);
  cover_warn_c: cover property ($rose(warning_pin));

endmodule // frw_supervisor
`default_nettype wire

/* File: testbench/frw_host_model.sv */
// Purpose: Host processor model on the management side of the supervisor.
// Assumes: Commands start on the falling edge of mclk and last one cycle.
// Notes: Only the clear-faults command and the enable pin are modelled.
`timescale 1ns/1ps
`default_nettype none
module frw_host_model
(
  input wire logic mclk,
  input wire logic warning_pin,
  output logic clear_faults,
  output logic enable_pin
);
  int alerts;

  initial
  begin
    clear_faults = 1'b0;
    enable_pin = 1'b1;
    alerts = 0;
  end

  // Alerts are only counted; the host reacts when the bench tells it to.
  always @(posedge warning_pin)
    alerts++;

  // The command is a single pulse, as the bus engine hands it over.
  task automatic send_clear();
    @(negedge mclk) clear_faults = 1'b1;
    @(negedge mclk) clear_faults = 1'b0;
  endtask

  // With the pin used as enable, a falling edge releases latch-off; the pin is raised again afterwards.
  task automatic drop_enable();
    @(negedge mclk) enable_pin = 1'b0;
    @(negedge mclk) enable_pin = 1'b1;
  endtask
endmodule // frw_host_model
`default_nettype wire

/* File: testbench/frw_supervisor_tb.sv */
// Purpose: Self-checking bench for the retry, latch-off and warning supervisor.
// Assumes: Inputs change on the falling edge; one millisecond is 10 clocks here.
// Notes: Expected values come from a small integer model beside the stimulus.
`timescale 1ns/1ps
`default_nettype none
module frw_supervisor_tb
  import frw_pkg::*;
;
  logic mclk, reset, rcd, gfr, nrn, eie, pgc, en_pin, clr, ep, epg;
  logic switch_off, retry_start, switch_check_start, strong_pullup, latch_off, mem_latch_off;
  logic warning_pin, fault_pin, power_good_pin;
  logic [2:0] rcf, cdf, dgf;
  logic [CNT_W-1:0] retries_used;
  frw_ctrl_e cs;
  frw_retry_fault_s rf, rm;
  frw_latch_fault_s lf;
  frw_warn_t wc, we, wm, es, warning_status;
  frw_fault_status_s fault_status;
  int fails, n_checks, exp_used, n;
  int cnt_lut[8] = '{0, 1, 2, 3, 4, 8, 16, 32};

  frw_supervisor #(.MS_CYCLES_P(10)) frw_supervisor_inst (
    .mclk, .reset, .ctrl_state(cs), .retry_fault(rf), .latch_fault(lf), .retry_mask(rm),
    .retry_count_field(rcf), .retry_counter_disable(rcd), .cooldown_time_field(cdf),
    .retry_ok_deglitch_field(dgf), .gate_fast_recovery_enable(gfr), .no_regulation_needed(nrn),
    .clear_faults(clr), .enable_pin(en_pin), .enable_pin_is_enable(eie), .power_good_cond(pgc),
    .warn_cond(wc), .warn_enable(we), .warn_mask(wm), .switch_off, .retry_start,
    .switch_check_start, .strong_pullup, .latch_off, .mem_latch_off, .retries_used,
    .fault_status, .warning_status, .warning_pin, .fault_pin, .power_good_pin
  );

  frw_host_model frw_host_model_inst (
    .mclk, .warning_pin, .clear_faults(clr), .enable_pin(en_pin)
  );

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("unexpected at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask

  task report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task do_reset();
    @(negedge mclk) reset = 1'b1;
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    exp_used = 0;
  endtask

  // One retryable fault pulse, judged against the retry counter model.
  task hit(input logic [4:0] b);
    logic lat, ur;
    ur = (b & rm) != 0 && !rcd && exp_used >= cnt_lut[rcf];
    lat = (b & rm) == 0 || ur;
    if (!lat && !rcd)
      exp_used++;
    @(negedge mclk) rf = b;
    @(negedge mclk) rf = '0;
    @(negedge mclk);
    chk({switch_off, fault_pin}, 2'b11);
    chk(retries_used, exp_used);
    @(negedge mclk);
    chk(retry_start, !lat);
    chk(latch_off, lat);
    chk(fault_status.unsuccessful_retry, ur);
    chk(fault_status.retry & b, b);
  endtask

  // Leaves latch-off by command or enable edge, then starts from reset.
  task rel(input bit use_en);
    if (use_en)
      frw_host_model_inst.drop_enable();
    else
      frw_host_model_inst.send_clear();
    chk({switch_check_start, latch_off, switch_off, warning_pin}, 4'b1000);
    chk(fault_status, 0);
    do_reset();
  endtask

  function automatic frw_warn_t qual();
    frw_warn_t q;
    logic on, wide;
    on = cs == CS_ON || cs == CS_CURRENT_REG;
    wide = on || cs inside {CS_STANDBY, CS_SOFTSTART, CS_FAULT};
    for (int i = 0; i < NUM_WARN; i++)
      q[i] = wc[i] && we[i] && (i == 0 ? cs == CS_ON : i <= 5 ? wide : i == 11 ? on || cs == CS_SOFTSTART :
                                i == 12 ? wide || cs == CS_LATCHED : on);
    return q;
  endfunction

  initial
  begin
    #(40 * 20000);
    fails++;
    report_and_stop();
  end

  initial
  begin
    reset = 1'b1; cs = CS_STANDBY; rf = '0; lf = '0; rcd = 1'b0; gfr = 1'b0; nrn = 1'b0;
    rm = '1;
    rcf = 3'h7; cdf = 3'h0; dgf = 3'h0; eie = 1'b1; pgc = 1'b0; wc = '0; we = '0; wm = '0;
    fails = 0; n_checks = 0; exp_used = 0; es = '0; ep = 1'b0; epg = 1'b0;
    void'($urandom(79));
    repeat (16) @(negedge mclk);
    reset = 1'b0;
    @(negedge mclk);
    chk({switch_off, latch_off, retries_used, warning_pin, fault_status}, 0);
    for (int i = 0; i < 5; i++)
      hit(5'h01 << i);
    cs = CS_ON;
    for (n = 0; n < 100 && retries_used !== 6'h00; n++)
      @(negedge mclk);
    chk(retries_used, 0);
    exp_used = 0;
    cs = CS_STANDBY;
    // Fast recovery with the longest cool-down: only the skip keeps this short.
    rcf = 3'h1; cdf = 3'h7; gfr = 1'b1; nrn = 1'b1;
    hit(5'h01);
    cs = CS_SOFTSTART;
    repeat (2) @(negedge mclk);
    chk(strong_pullup, 1);
    cs = CS_STANDBY;
    repeat (2) @(negedge mclk);
    chk(strong_pullup, 0);
    hit(5'h01);
    we = '1; wm = '1; wc = 13'h0002;
    repeat (3) @(negedge mclk);
    chk({warning_status, warning_pin, switch_off}, 14'h0001);
    wc = '0; gfr = 1'b0; cdf = 3'h0;
    rel(0);
    rcf = 3'h0;
    hit(5'h10);
    // With the pin not used as enable, its falling edge must not release latch-off.
    eie = 1'b0;
    frw_host_model_inst.drop_enable();
    chk({latch_off, switch_check_start}, 2'b10);
    eie = 1'b1;
    rel(1);
    rcf = 3'h7; rm = 5'h1e;
    hit(5'h01);
    rm = '1;
    rel(0);
    for (int j = 0; j < 4; j++)
    begin
      @(negedge mclk) lf = 4'h1 << j;
      @(negedge mclk) lf = '0;
      repeat (2) @(negedge mclk);
      chk({switch_off, latch_off, mem_latch_off}, j == 3 ? 3'b101 : 3'b110);
      chk(fault_status.latch, 4'h1 << j);
      if (j < 3)
        rel(0);
      else
      begin
        frw_host_model_inst.send_clear();
        @(negedge mclk);
        chk({switch_check_start, mem_latch_off}, 2'b01);
        do_reset();
        chk(mem_latch_off, 0);
      end
    end
    rcd = 1'b1; rcf = 3'h0;
    repeat (3) hit(5'h02);
    rcd = 1'b0; rcf = 3'h7; cdf = 3'h1;
    @(negedge mclk) rf = 5'h04;
    @(negedge mclk) rf = '0;
    frw_host_model_inst.send_clear();
    frw_host_model_inst.drop_enable();
    chk({switch_off, switch_check_start, fault_status.retry[2]}, 3'b101);
    for (n = 6; n < 1500 && retry_start !== 1'b1; n++)
      @(negedge mclk);
    chk(n >= 990 && n < 1500, 1);
    do_reset();
    // Random warning traffic, bus error excluded, across every controller state except latched.
    for (n = 0; n < 200; n++)
    begin
      @(negedge mclk);
      chk(warning_status, es);
      chk({warning_pin, switch_off, power_good_pin}, {ep, 1'b0, epg});
      cs = frw_ctrl_e'($urandom_range(0, 7));
      wc = frw_warn_t'($urandom) & 13'h0fff;
      we = frw_warn_t'($urandom);
      wm = frw_warn_t'($urandom);
      pgc = 1'($urandom);
      epg = pgc;
      es = es | qual();
      ep = |(qual() & wm);
    end
    // The last random inputs must reach the design before they are replaced.
    @(negedge mclk);
    chk({warning_status, warning_pin}, {es, ep});
    cs = CS_STANDBY;
    wc = '0;
    @(negedge mclk);
    chk({warning_status, warning_pin}, {es, 1'b0});
    frw_host_model_inst.send_clear();
    @(negedge mclk);
    chk(warning_status, 0);
    report_and_stop();
  end
endmodule // frw_supervisor_tb
`default_nettype wire
